// *** rtl/scwt_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module scwt_top
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic i_xtal_tick,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic o_aux_clk_pin,
  output logic o_aux_clk_oe,
  output logic o_wake_irq,
  output logic o_irq
);
  import scwt_pkg::*;
  scwt_req_t req;
  logic [7:0] aux_ctrl_ff;
  logic [7:0] wake_sc_ff;
  logic wake_flag_ff;
  logic stat_ff;
  logic en_ff;
  logic [14:0] slow_cnt_ff;
  logic slow_tick_ff;
  logic [3:0] div_cnt_ff;
  logic timeout;
  logic wr_en;
  logic rd_en;
  assign req = '{address: i_address, read: i_read, write: i_write, writedata: i_writedata};
  assign wr_en = req.write && !o_waitrequest;
  assign rd_en = req.read && o_waitrequest;

  // One wait cycle per access, waitrequest straight from a flip-flop
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_waitrequest <= 1'b1;
    else
      o_waitrequest <= !((req.read || req.write) && o_waitrequest);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_readdata <= 32'h00000000;
    else if (rd_en)
    begin
      unique case (req.address)
        ADDR_AUX_CTRL: o_readdata <= {24'h000000, 3'h0, aux_ctrl_ff[AUX_PIN_EN_BIT], 1'b0,
                                      aux_ctrl_ff[2:0]};
        ADDR_ID_HIGH: o_readdata <= {24'h000000, 4'h0, PART_ID[11:8]}; // R4 R5
        ADDR_ID_LOW: o_readdata <= {24'h000000, PART_ID[7:0]}; // R5
        ADDR_WAKE_SC: o_readdata <= {24'h000000, wake_flag_ff, 1'b0, wake_sc_ff[5:4], 1'b0,
                                     wake_sc_ff[2:0]}; // R7 R13
        ADDR_IRQ_STAT: o_readdata <= {31'h00000000, stat_ff};
        ADDR_IRQ_EN: o_readdata <= {31'h00000000, en_ff};
        default: o_readdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      aux_ctrl_ff <= AUX_CTRL_RST;
      wake_sc_ff <= WAKE_SC_RST;
      en_ff <= 1'b0;
    end
    else if (wr_en)
    begin
      if (req.address == ADDR_AUX_CTRL)
        aux_ctrl_ff <= req.writedata[7:0];
      if (req.address == ADDR_WAKE_SC)
        wake_sc_ff <= req.writedata[7:0]; // R8 R9
      if (req.address == ADDR_IRQ_EN)
        en_ff <= req.writedata[0];
    end
  end

  // Wake flag: set wins over acknowledge
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      wake_flag_ff <= 1'b0;
    else if (timeout)
      wake_flag_ff <= 1'b1; // R6
    else if (wr_en && req.address == ADDR_WAKE_SC && req.writedata[WAKE_ACK_BIT])
      wake_flag_ff <= 1'b0; // R7
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      stat_ff <= 1'b0;
    else if (timeout)
      stat_ff <= 1'b1;
    else if (wr_en && req.address == ADDR_IRQ_CLR && req.writedata[0])
      stat_ff <= 1'b0;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_wake_irq <= 1'b0;
      o_irq <= 1'b0;
    end
    else
    begin
      o_wake_irq <= wake_flag_ff && wake_sc_ff[WAKE_IE_BIT]; // R9 R14
      o_irq <= stat_ff && en_ff;
    end
  end

  // Internal 1 kHz tick
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      slow_cnt_ff <= 15'h0000;
      slow_tick_ff <= 1'b0;
    end
    else if (slow_cnt_ff == 15'(SLOW_DIV - 1))
    begin
      slow_cnt_ff <= 15'h0000;
      slow_tick_ff <= 1'b1;
    end
    else
    begin
      slow_cnt_ff <= slow_cnt_ff + 15'h0001;
      slow_tick_ff <= 1'b0;
    end
  end

  scwt_wake_timer u_timer
  (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_tick(wake_sc_ff[WAKE_SRC_BIT] ? i_xtal_tick : slow_tick_ff), // R8
    .i_src_xtal(wake_sc_ff[WAKE_SRC_BIT]),
    .i_delay_sel(wake_sc_ff[2:0]),
    .o_timeout(timeout)
  );

  // Aux clock: half period of select bus cycles
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      div_cnt_ff <= 4'h0;
      o_aux_clk_pin <= 1'b0;
      o_aux_clk_oe <= 1'b0;
    end
    else
    begin
      o_aux_clk_oe <= aux_ctrl_ff[AUX_PIN_EN_BIT]; // R1
      if (!aux_ctrl_ff[AUX_PIN_EN_BIT] || aux_ctrl_ff[2:0] == 3'h0)
      begin
        div_cnt_ff <= 4'h0;
        o_aux_clk_pin <= 1'b0; // R3
      end
      else if (div_cnt_ff >= {1'b0, aux_ctrl_ff[2:0]} - 4'h1)
      begin
        div_cnt_ff <= 4'h0;
        o_aux_clk_pin <= !o_aux_clk_pin; // R2
      end
      else
        div_cnt_ff <= div_cnt_ff + 4'h1;
    end
  end
endmodule // scwt_top
`default_nettype wire

// *** rtl/scwt_pkg.sv ***
// Functional notes
// (R1) Aux clock drives pin only when enabled
// (R2) Aux clock is bus clock over twice select
// (R3) Zero divide select with enable holds low
// (R4) High id bits 7:4 reserved, writes ignored
// (R5) Fixed 12-bit id split over two bytes
// (R6) Wake flag sets on timer timeout
// (R7) Writing one to ack clears flag
// (R8) Source select picks 1 kHz or crystal
// (R9) Irq enable gates the wake interrupt
// (R10) Delay select zero disables the timer
// (R11) Internal delays 8 ms to 1.024 s
// (R12) Crystal divides 256 up to 32768
// (R13) Unimplemented status bits read zero
// (R14) Irq high while flag and enable set
package scwt_pkg;
  localparam logic [3:0] ADDR_AUX_CTRL = 4'h0;
  localparam logic [3:0] ADDR_ID_HIGH = 4'h1;
  localparam logic [3:0] ADDR_ID_LOW = 4'h2;
  localparam logic [3:0] ADDR_WAKE_SC = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h5;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h6;
  localparam int AUX_PIN_EN_BIT = 4;
  localparam int WAKE_FLAG_BIT = 7;
  localparam int WAKE_ACK_BIT = 6;
  localparam int WAKE_SRC_BIT = 5;
  localparam int WAKE_IE_BIT = 4;
  // Arbitrary neutral identification value
  localparam logic [11:0] PART_ID = 12'h5a3;
  localparam logic [7:0] AUX_CTRL_RST = 8'h00;
  localparam logic [7:0] WAKE_SC_RST = 8'h00;
  localparam int CLK_HZ = 25000000;
  localparam int SLOW_HZ = 1000;
  localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } scwt_req_t;
endpackage

// *** rtl/scwt_wake_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
module scwt_wake_timer
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic i_src_xtal,
  input wire logic [2:0] i_delay_sel,
  output logic o_timeout
);
  import scwt_pkg::*;
  logic [14:0] cnt_ff;
  logic [14:0] term;
  always_comb
  begin
    unique case (i_delay_sel)
      3'h1: term = i_src_xtal ? 15'h00ff : 15'h0007; // R11 R12
      3'h2: term = i_src_xtal ? 15'h03ff : 15'h001f;
      3'h3: term = i_src_xtal ? 15'h07ff : 15'h003f;
      3'h4: term = i_src_xtal ? 15'h0fff : 15'h007f;
      3'h5: term = i_src_xtal ? 15'h1fff : 15'h00ff;
      3'h6: term = i_src_xtal ? 15'h3fff : 15'h01ff;
      3'h7: term = i_src_xtal ? 15'h7fff : 15'h03ff;
      default: term = 15'h0000;
    endcase
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_ff <= 15'h0000;
      o_timeout <= 1'b0;
    end
    else
    begin
      o_timeout <= 1'b0;
      if (i_delay_sel == 3'h0)
        cnt_ff <= 15'h0000; // R10
      else if (i_tick)
      begin
        if (cnt_ff >= term)
        begin
          cnt_ff <= 15'h0000;
          o_timeout <= 1'b1;
        end
        else
          cnt_ff <= cnt_ff + 15'h0001;
      end
    end
  end
endmodule // scwt_wake_timer
`default_nettype wire

// *** tb/scwt_top_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module scwt_top_props
  import scwt_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic i_xtal_tick,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic o_aux_clk_pin,
  input wire logic o_aux_clk_oe,
  input wire logic o_wake_irq,
  input wire logic o_irq
);
  logic rd_ok;
  logic wr_ok;
  logic wk_wr;
  assign rd_ok = i_read && !o_waitrequest;
  assign wr_ok = i_write && !o_waitrequest;
  assign wk_wr = wr_ok && i_address == ADDR_WAKE_SC;
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_pin_off: assert property (!o_aux_clk_oe |-> !o_aux_clk_pin) else $error("pin on");
  a_oe_set: assert property (wr_ok && i_address == ADDR_AUX_CTRL
    |-> ##2 o_aux_clk_oe == $past(i_writedata[4], 2)) else $error("oe");
  a_id_high: assert property (rd_ok && i_address == ADDR_ID_HIGH
    |-> o_readdata == {28'h0, PART_ID[11:8]}) else $error("idh");
  a_id_low: assert property (rd_ok && i_address == ADDR_ID_LOW
    |-> o_readdata == {24'h0, PART_ID[7:0]}) else $error("idl");
  a_wake_zero: assert property (rd_ok && i_address == ADDR_WAKE_SC
    |-> !o_readdata[6] && !o_readdata[3]) else $error("zero bits");
  a_ack_clr: assert property (wk_wr && i_writedata[6] |-> ##2 !o_wake_irq) else $error("ack");
  a_ie_gate: assert property (wk_wr && !i_writedata[4] |-> ##2 !o_wake_irq) else $error("ie");
  a_irq_clr: assert property (wr_ok && i_address == ADDR_IRQ_CLR && i_writedata[0]
    |-> ##2 !o_irq) else $error("clr");
  c_wake: cover property ($rose(o_wake_irq));
  c_aux: cover property ($rose(o_aux_clk_pin));
  c_irq: cover property ($fell(o_irq));
endmodule // scwt_top_props
bind scwt_top scwt_top_props i_props (.i_sys_clk, .i_rst_n, .i_address, .i_read, .i_write,
  .i_writedata, .i_xtal_tick, .o_readdata, .o_waitrequest, .o_aux_clk_pin, .o_aux_clk_oe,
  .o_wake_irq, .o_irq);
`default_nettype wire

// *** tb/tb_scwt_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_scwt_top;
  import scwt_pkg::*;
  logic i_sys_clk = 1'h0;
  logic i_rst_n = 1'h0;
  logic [3:0] i_address = 4'h0;
  logic i_read = 1'h0;
  logic i_write = 1'h0;
  logic [31:0] i_writedata = 32'h0;
  logic i_xtal_tick = 1'h0;
  logic [31:0] o_readdata, rd;
  logic o_waitrequest, o_aux_clk_pin, o_aux_clk_oe, o_wake_irq, o_irq;
  int err_total = 0;
  int samples_checked = 0;
  scwt_top i_dut (.i_sys_clk, .i_rst_n, .i_address, .i_read, .i_write, .i_writedata,
    .i_xtal_tick, .o_readdata, .o_waitrequest, .o_aux_clk_pin, .o_aux_clk_oe,
    .o_wake_irq, .o_irq);
  initial forever #20 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) i_xtal_tick <= ~i_xtal_tick;
  task automatic tk(input int k);
    repeat (k) @(posedge i_sys_clk);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    tk(1);
    i_read <= !w;
    i_write <= w;
    i_address <= a;
    i_writedata <= d;
    do
    begin
      tk(1);
      n++;
    end
    while (o_waitrequest !== 1'b0 && n < 50);
    rd = o_readdata;
    chk(o_waitrequest, 0);
    i_read <= 1'h0;
    i_write <= 1'h0;
  endtask
  task automatic t_regs;
    bus(1, ADDR_ID_HIGH, 32'hff);
    bus(0, ADDR_ID_HIGH, 0);
    chk(rd, {28'h0, PART_ID[11:8]});
    bus(0, ADDR_ID_LOW, 0);
    chk(rd, {24'h0, PART_ID[7:0]});
    bus(1, 4'hf, 32'hff);
    bus(0, 4'hf, 0);
    chk(rd, 0);
    bus(1, ADDR_WAKE_SC, 32'hff);
    bus(0, ADDR_WAKE_SC, 0);
    chk(rd, 32'h37);
    bus(1, ADDR_WAKE_SC, 0);
  endtask
  task automatic t_aux;
    time t0;
    bus(1, ADDR_AUX_CTRL, 32'h13);
    @(posedge o_aux_clk_pin);
    t0 = $time;
    @(posedge o_aux_clk_pin);
    chk(32'(($time - t0) / 40), 6);
    bus(1, ADDR_AUX_CTRL, 32'h10);
    tk(8);
    chk({o_aux_clk_oe, o_aux_clk_pin}, 2);
    bus(1, ADDR_AUX_CTRL, 0);
    tk(2);
    chk({o_aux_clk_oe, o_aux_clk_pin}, 0);
  endtask
  task automatic t_wake;
    int n;
    n = 0;
    bus(1, ADDR_IRQ_EN, 1);
    bus(1, ADDR_WAKE_SC, 32'h31);
    while (o_wake_irq !== 1'b1 && n < 2000)
    begin
      tk(1);
      n++;
    end
    chk(n > 490 && n < 530, 1);
    chk(o_irq, 1);
    bus(0, ADDR_WAKE_SC, 0);
    chk(rd, 32'hb1);
    bus(0, ADDR_IRQ_STAT, 0);
    chk(rd, 1);
    bus(0, ADDR_WAKE_SC, 0);
    bus(1, ADDR_WAKE_SC, 32'h71);
    tk(2);
    chk(o_wake_irq, 0);
    bus(1, ADDR_IRQ_EN, 0);
    tk(2);
    chk({o_irq, 7'h0, rd[7:0]}, 32'hb1);
    bus(1, ADDR_IRQ_CLR, 1);
    bus(1, ADDR_IRQ_EN, 1);
    tk(1);
    chk(o_irq, 0);
    bus(1, ADDR_WAKE_SC, 32'h21);
    tk(600);
    bus(0, ADDR_WAKE_SC, 0);
    chk({o_wake_irq, rd[7:0]}, 32'ha1);
    bus(1, ADDR_WAKE_SC, 32'h50);
    tk(1200);
    bus(0, ADDR_WAKE_SC, 0);
    chk({o_wake_irq, rd[7:0]}, 32'h10);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    tk(6);
    i_rst_n <= 1'h1;
    t_regs;
    $display("regs done");
    t_aux;
    $display("aux done");
    t_wake;
    $display("wake done");
    report_and_stop;
  end
  initial
  begin
    tk(20000);
    err_total++;
    report_and_stop;
  end
endmodule // tb_scwt_top
`default_nettype wire
